// >>> pkg/cbc_consts.svh
// Purpose: Constants of the cell balance controller.
// Assumes: Included by the top module and the testbench only.
// Notes:   Offsets are APB byte addresses; times are in their own units.
`ifndef CBC_CONSTS_SVH
`define CBC_CONSTS_SVH
// Clock rate in kHz (20 MHz).
`define CBC_CLK_KHZ 20000
// Measurement and bleed phases of one cycle, and the whole cycle.
`define CBC_MEAS_MS 50
`define CBC_BAL_MS 200
`define CBC_CYCLE_MS 250
// Least dwell time between selection updates, in tenths of a minute.
`define CBC_DWELL_DMIN 75
// One hour in milliseconds, the base of the time-out.
`define CBC_HOUR_MS 3600000
// Least protection delay, in ms, and the unit of the delay fields.
`define CBC_PROT_MIN_MS 500
`define CBC_PROT_UNIT_MS 100
// Register byte offsets.
`define CBC_CTRL_OFS 12'h000
`define CBC_DLY_OFS 12'h004
`define CBC_STAT_OFS 12'h008
// Control field positions.
`define CBC_MODE_LSB 0
`define CBC_TSEL_LSB 2
`define CBC_VTH_LSB 4
// Delay field positions.
`define CBC_OVD_LSB 0
`define CBC_UVD_LSB 8
// Status field positions.
`define CBC_ST_SEL_LSB 8
`define CBC_ST_TRUN 9
`define CBC_ST_TEXP 10
`define CBC_ST_MEAS 11
`define CBC_ST_CHG 12
// Reset values: balancing off, start threshold code 15 (3.9 V).
`define CBC_MODE_RST 2'h0
`define CBC_TSEL_RST 2'h0
`define CBC_VTH_RST 4'hf
`endif

// >>> pkg/cbc_pkg.sv
// Purpose: Types of the cell balance controller.
// Assumes: Up to eight cells.
// Notes:   Timing counts live in the header as macros.
package cbc_pkg;
    // Widest cell stack the state can hold.
    localparam int CBC_NMAX = 8;

    // Balance enable modes.
    typedef enum logic [1:0] {
        CBC_MODE_OFF = 2'b00,
        CBC_MODE_TIMER = 2'b01,
        CBC_MODE_CHG = 2'b10,
        CBC_MODE_BOTH = 2'b11
    } cbc_mode_t;

    // Phase of the repeating measure/bleed cycle.
    typedef enum logic {
        CBC_PH_MEAS = 1'b0,
        CBC_PH_BAL = 1'b1
    } cbc_phase_t;

    // Whole state of the controller.
    typedef struct packed {
        logic chg_s1;
        logic chg_s2;
        cbc_phase_t phase;
        logic [22:0] cyc_cnt;
        logic [15:0] dwell_cnt;
        logic [2:0] sel_idx;
        logic sel_valid;
        logic tmr_run;
        logic tmr_exp;
        logic [16:0] tmr_cnt;
        cbc_mode_t mode;
        logic [1:0] tsel;
        logic [3:0] vth;
        logic [7:0] ov_dly;
        logic [7:0] uv_dly;
        logic [CBC_NMAX-1:0] bleed;
        logic meas_en;
        logic freeze;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cbc_state_t;
endpackage : cbc_pkg

// >>> rtl/cbc_top.sv
// Purpose: Hardware cell-balancing sequencer with an APB register slave.
// Assumes: Cell comparison and fault-timer inputs come from logic on
//          pclk; only the charger detect arrives from a pin.
// Notes:   Overview of operation
// Overview of operation
// R1: Selection latched once per dwell, 7.5 minutes.
// R2: Bleed highest cell above threshold, no hysteresis.
// R3: At most one bleed drive at once.
// R4: Expired timer clears and stops selection.
// R5: Suppress bleed on four listed conditions.
// R6: 250 ms cycles: 50 ms measure, 200 ms bleed.
// R7: Freeze measurements while any bleed is on.
// R8: Protection delays never below 500 ms.
// R9: Pause bleeding while OV/UV delay runs.
// R10: Resume bleeding once OV/UV timing ends.
// R11: Time-out of 1, 2, 4 or 8 hours.
// R12: Timer starts when balancing first begins.
// R13: Charger loss stops bleeding at once.
// R14: Start threshold 4 bits, 2.4-3.9 V, default 3.9.
// R15: Enable mode: charger, timer, or both.
// R16: Enable field zero keeps bleeding off.
// R17: Shutdown keeps balancing inactive.
// R18: System should enable the time-out.
// R19: One separate comparator judges start threshold.
// R20: Ties go to the lowest-numbered cell.
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ns
`include "cbc_consts.svh"

module cbc_top
    import cbc_pkg::*;
#(
    parameter int N_CELLS = 8,
    parameter int MEAS_CYC = `CBC_MEAS_MS * `CBC_CLK_KHZ,
    parameter int BAL_CYC = `CBC_BAL_MS * `CBC_CLK_KHZ,
    parameter int DWELL_TICKS =
        (`CBC_DWELL_DMIN * 6000 + `CBC_CYCLE_MS - 1) / `CBC_CYCLE_MS,
    parameter int HOUR_TICKS = `CBC_HOUR_MS / `CBC_CYCLE_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [N_CELLS-1:0] cell_is_max,
    input wire logic max_above_start,
    input wire logic charger_det,
    input wire logic ov_timing,
    input wire logic uv_timing,
    input wire logic shutdown_mode,
    output logic [N_CELLS-1:0] bleed_drive,
    output logic meas_active,
    output logic meas_freeze,
    output logic [3:0] start_vth_code,
    output logic [7:0] ov_delay_units,
    output logic [7:0] uv_delay_units
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Counter widths in the state bound what the parameters may be.
    initial begin
        if (N_CELLS < 4 || N_CELLS > CBC_NMAX) begin
            $error("N_CELLS must be 4 to 8.");
        end
        if (MEAS_CYC < 1 || BAL_CYC < 1 ||
            MEAS_CYC + BAL_CYC > 23'h7f_ffff) begin
            $error("Phase lengths do not fit the cycle counter.");
        end
        if (DWELL_TICKS < 1 || DWELL_TICKS > 65535) begin
            $error("DWELL_TICKS out of range.");
        end
        if (HOUR_TICKS < 1 || HOUR_TICKS * 8 > 131071) begin
            $error("HOUR_TICKS out of range.");
        end
    end

    localparam logic [22:0] MEAS_LAST = 23'(MEAS_CYC - 1);
    localparam logic [22:0] BAL_LAST = 23'(BAL_CYC - 1);
    localparam logic [15:0] DWELL_LAST = 16'(DWELL_TICKS - 1);
    localparam logic [7:0] PROT_MIN =
        8'(`CBC_PROT_MIN_MS / `CBC_PROT_UNIT_MS);

    // ****************************************************************
    // Design notes
    // ****************************************************************
    // The cycle counter runs a measure phase and then a bleed phase.
    // The end of each bleed phase is one tick of the slower counters.
    // The dwell counter and the balance timer both count these ticks,
    // so their resolution is one whole cycle and not one clock.
    // A selection is taken only when the dwell counter wraps. Between
    // wraps the chosen cell stays fixed, which keeps the bleed from
    // hopping between two cells that sit a few millivolts apart.
    // The bleed gates are applied every clock, not once per dwell, so
    // a fault being timed or a highest cell that drops below the start
    // voltage ends the bleed on the next clock, a lost charger on the third.
    // The threshold comparison has no hysteresis, by intent; a cell
    // near the start voltage may toggle the bleed from one clock to
    // the next, and whoever owns the comparator must filter it if
    // that matters.
    // The timer starts on the first crossing of the start voltage and
    // is sticky once it expires. Only a control write or a shutdown
    // clears it, so a pack left on a dead charger cannot restart
    // balancing by itself.
    // The delay fields are clamped on write, not on read, so the fault
    // timers always see the stored, legal value.
    // The bus answers one cycle after the access cycle. Writes commit
    // at the edge at which that answer is sampled high, never earlier.
    // The charger detect is the only input from outside the clock
    // domain. It passes two flops and adds two cycles of lag; all
    // other inputs are taken as they are.
    // A frozen clock enable stalls everything, the synchroniser too,
    // so a long freeze can hide a short charger drop entirely.

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Lowest-numbered set flag, so ties pick one cell every time.
    function automatic logic [2:0] lowest_set(
        input logic [CBC_NMAX-1:0] flags
    );
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = CBC_NMAX - 1; i >= 0; i--) begin
            if (flags[i]) begin
                idx = 3'(i); // R20
            end
        end
        return idx;
    endfunction : lowest_set

    // Delay write value raised to the least legal setting.
    function automatic logic [7:0] clamp_dly(input logic [7:0] v);
        return (v < PROT_MIN) ? PROT_MIN : v; // R8
    endfunction : clamp_dly

    // ****************************************************************
    // State
    // ****************************************************************
    cbc_state_t st_r;
    cbc_state_t st_nxt;

    logic [CBC_NMAX-1:0] max_flags;
    logic tick;
    logic dwell_due;
    logic chg_ok;
    logic tmr_block;
    logic [16:0] tmr_limit;
    logic apb_acc;
    logic apb_wr;
    logic [31:0] rd_word;
    logic rd_hit;

    // Widen the per-cell flags to the state width.
    always_comb begin
        max_flags = '0;
        max_flags[N_CELLS-1:0] = cell_is_max;
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    // Everything advances here; the register stage below only applies it.
    always_comb begin
        st_nxt = st_r;
        tick = 1'b0;
        dwell_due = 1'b0;
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;

        // The pin is caught by two flops; only the second is read.
        st_nxt.chg_s1 = charger_det;
        st_nxt.chg_s2 = st_r.chg_s1;

        // Cycle sequencer: measure phase, then bleed phase.
        if (st_r.phase == CBC_PH_MEAS) begin // R6
            if (st_r.cyc_cnt == MEAS_LAST) begin
                st_nxt.phase = CBC_PH_BAL;
                st_nxt.cyc_cnt = 23'h00_0000;
            end else begin
                st_nxt.cyc_cnt = st_r.cyc_cnt + 23'h00_0001;
            end
        end else begin
            if (st_r.cyc_cnt == BAL_LAST) begin
                st_nxt.phase = CBC_PH_MEAS;
                st_nxt.cyc_cnt = 23'h00_0000;
                tick = 1'b1;
            end else begin
                st_nxt.cyc_cnt = st_r.cyc_cnt + 23'h00_0001;
            end
        end

        // Dwell counter in whole cycles; update when it wraps.
        if (tick) begin
            if (st_r.dwell_cnt == DWELL_LAST) begin // R1
                st_nxt.dwell_cnt = 16'h0000;
                dwell_due = 1'b1;
            end else begin
                st_nxt.dwell_cnt = st_r.dwell_cnt + 16'h0001;
            end
        end

        // Balance timer: starts at first start-threshold crossing.
        tmr_limit = 17'(HOUR_TICKS) << st_r.tsel; // R11
        if (st_r.mode != CBC_MODE_OFF && !st_r.tmr_run &&
            !st_r.tmr_exp && max_above_start) begin
            st_nxt.tmr_run = 1'b1; // R12
            st_nxt.tmr_cnt = 17'h0_0000;
        end else if (st_r.tmr_run && tick) begin
            if (st_r.tmr_cnt + 17'h0_0001 >= tmr_limit) begin
                st_nxt.tmr_run = 1'b0;
                st_nxt.tmr_exp = 1'b1;
            end else begin
                st_nxt.tmr_cnt = st_r.tmr_cnt + 17'h0_0001;
            end
        end
        tmr_block = st_r.tmr_exp &&
            (st_r.mode == CBC_MODE_TIMER || st_r.mode == CBC_MODE_BOTH);

        // Selection: once per dwell, cleared and idle after expiry in the timer and both modes.
        if (tmr_block) begin
            st_nxt.sel_valid = 1'b0; // R4
        end else if (dwell_due) begin
            st_nxt.sel_valid = max_above_start && (max_flags != '0); // R2
            st_nxt.sel_idx = lowest_set(max_flags); // R20
        end

        // Charger gate applies in the modes that balance only on charge.
        chg_ok = st_r.chg_s2 ||
            !(st_r.mode == CBC_MODE_CHG || st_r.mode == CBC_MODE_BOTH);

        // Bleed drive: one-hot of the selection, gated every cycle.
        st_nxt.bleed = '0;
        if (st_r.mode != CBC_MODE_OFF && // R16 R15
            st_r.sel_valid && !tmr_block && // R5
            max_above_start && // R5 R2
            st_r.phase == CBC_PH_BAL && // R5
            chg_ok && // R13
            !ov_timing && !uv_timing) begin // R9 R10
            st_nxt.bleed[st_r.sel_idx] = 1'b1; // R3
        end
        // A fresh selection takes effect one cycle later via sel_idx.
        st_nxt.meas_en = (st_nxt.phase == CBC_PH_MEAS);
        st_nxt.freeze = (st_nxt.bleed != '0); // R7

        // APB slave: answer on the second access cycle.
        apb_acc = psel && penable && !st_r.pready;
        // Writes land at the edge that samples the answer high.
        apb_wr = psel && penable && pwrite && st_r.pready;
        case (paddr)
            `CBC_CTRL_OFS: begin
                rd_word[`CBC_MODE_LSB +: 2] = st_r.mode;
                rd_word[`CBC_TSEL_LSB +: 2] = st_r.tsel;
                rd_word[`CBC_VTH_LSB +: 4] = st_r.vth;
            end
            `CBC_DLY_OFS: begin
                rd_word[`CBC_OVD_LSB +: 8] = st_r.ov_dly;
                rd_word[`CBC_UVD_LSB +: 8] = st_r.uv_dly;
            end
            `CBC_STAT_OFS: begin
                rd_word[CBC_NMAX-1:0] = st_r.bleed;
                rd_word[`CBC_ST_SEL_LSB] = st_r.sel_valid;
                rd_word[`CBC_ST_TRUN] = st_r.tmr_run;
                rd_word[`CBC_ST_TEXP] = st_r.tmr_exp;
                rd_word[`CBC_ST_MEAS] = st_r.meas_en;
                rd_word[`CBC_ST_CHG] = st_r.chg_s2;
                rd_word[15:13] = st_r.sel_idx;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
        st_nxt.pready = apb_acc;
        st_nxt.pslverr = apb_acc && !rd_hit;
        st_nxt.prdata = (apb_acc && !pwrite) ? rd_word : 32'h0000_0000;
        if (apb_wr && paddr == `CBC_CTRL_OFS) begin
            st_nxt.mode = cbc_mode_t'(pwdata[`CBC_MODE_LSB +: 2]);
            st_nxt.tsel = pwdata[`CBC_TSEL_LSB +: 2];
            st_nxt.vth = pwdata[`CBC_VTH_LSB +: 4]; // R14
            // A new setting restarts the time-out from scratch.
            st_nxt.tmr_run = 1'b0;
            st_nxt.tmr_exp = 1'b0;
            st_nxt.tmr_cnt = 17'h0_0000;
        end
        if (apb_wr && paddr == `CBC_DLY_OFS) begin
            st_nxt.ov_dly = clamp_dly(pwdata[`CBC_OVD_LSB +: 8]); // R8
            st_nxt.uv_dly = clamp_dly(pwdata[`CBC_UVD_LSB +: 8]); // R8
        end

        // Shutdown: balancing state is cleared and held idle.
        if (shutdown_mode) begin // R17
            st_nxt.phase = CBC_PH_MEAS;
            st_nxt.cyc_cnt = 23'h00_0000;
            st_nxt.dwell_cnt = 16'h0000;
            st_nxt.sel_valid = 1'b0;
            st_nxt.tmr_run = 1'b0;
            st_nxt.tmr_exp = 1'b0;
            st_nxt.tmr_cnt = 17'h0_0000;
            st_nxt.bleed = '0;
            st_nxt.meas_en = 1'b0;
            st_nxt.freeze = 1'b0;
        end
    end

    // ****************************************************************
    // Register stage
    // ****************************************************************
    // The clock enable freezes every flop, bus answer included.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.phase <= CBC_PH_MEAS;
            st_r.mode <= cbc_mode_t'(`CBC_MODE_RST);
            st_r.tsel <= `CBC_TSEL_RST;
            st_r.vth <= `CBC_VTH_RST; // R14
            st_r.ov_dly <= PROT_MIN; // R8
            st_r.uv_dly <= PROT_MIN; // R8
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // All outputs are flop bits of the state.
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign bleed_drive = st_r.bleed[N_CELLS-1:0];
    assign meas_active = st_r.meas_en;
    assign meas_freeze = st_r.freeze; // R7
    assign start_vth_code = st_r.vth; // R19
    assign ov_delay_units = st_r.ov_dly;
    assign uv_delay_units = st_r.uv_dly;

endmodule : cbc_top

// >>> tb/cbc_monitor.sv
// Purpose: Port-level checks of the cell balance controller.
// Assumes: Bound to cbc_top; one clock domain.
// Notes:   The measurement phase length comes from the bound parameter value.
`timescale 1ns/1ns
module cbc_monitor #(
    parameter int N_CELLS = 8,
    parameter int MEAS_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic max_above_start,
    input wire logic ov_timing,
    input wire logic uv_timing,
    input wire logic shutdown_mode,
    input wire logic [N_CELLS-1:0] bleed_drive,
    input wire logic meas_active,
    input wire logic meas_freeze,
    input wire logic [7:0] ov_delay_units,
    input wire logic [7:0] uv_delay_units
);
    // ************************************************************
    // Helper logic and assertions
    // ************************************************************
    logic [15:0] mcnt_r;
    logic full_r;

    // The first phase after reset or shutdown shows its indicator one
    // cycle late, so only phases that follow an earlier one are measured.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_r <= 1'b0;
        end else if (clk_en) begin
            if (shutdown_mode) begin
                full_r <= 1'b0;
            end else if (!meas_active && mcnt_r != 16'h0000) begin
                full_r <= 1'b1;
            end
        end
    end

    // Length of the running measurement phase; it stalls with clk_en,
    // as the phase itself does, so a frozen clock is not miscounted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcnt_r <= 16'h0000;
        end else if (clk_en) begin
            mcnt_r <= meas_active ? mcnt_r + 16'h0001 : 16'h0000;
        end
    end

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_one_bleed: assert property ($onehot0(bleed_drive))
        else $error("More than one bleed drive is on.");
    a_meas_quiet: assert property (
        meas_active && $past(meas_active) |-> bleed_drive == '0)
        else $error("Bleeding during measurement.");
    a_meas_len: assert property (
        $fell(meas_active) && full_r |-> mcnt_r == 16'(MEAS_CYC))
        else $error("Measurement phase has the wrong length.");
    a_freeze_on: assert property (bleed_drive != '0 |-> meas_freeze)
        else $error("Measurements not frozen while bleeding.");
    a_fault_pause: assert property (
        ov_timing || uv_timing |=> bleed_drive == '0)
        else $error("Bleeding while a fault is timed.");
    a_shut_off: assert property (shutdown_mode |=> bleed_drive == '0)
        else $error("Bleeding in shutdown.");
    a_below_off: assert property (
        !max_above_start |=> bleed_drive == '0)
        else $error("Bleeding below the start threshold.");
    a_dly_floor: assert property (
        ov_delay_units >= 8'h05 && uv_delay_units >= 8'h05)
        else $error("Protection delay below its floor.");
    a_apb_wait: assert property (
        psel && penable && !pready && clk_en |=> pready ##1 !pready)
        else $error("Bus answer not one cycle after access.");
endmodule : cbc_monitor

// >>> tb/cbc_pack_model.sv
// Purpose: Cell stack and charger detect as seen by the controller.
// Assumes: The bench names the highest cells and the charger state.
// Notes:   Comparator results settle one clock after a change.
`timescale 1ns/1ns
module cbc_pack_model #(
    parameter int N_CELLS = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N_CELLS-1:0] want_max,
    input wire logic want_above,
    input wire logic want_chg,
    output logic [N_CELLS-1:0] cell_is_max,
    output logic max_above_start,
    output logic charger_det
);
    // ************************************************************
    // Registered comparator and detect outputs
    // ************************************************************
    // The real comparators are clocked, so the model never answers in
    // the same cycle; this keeps the bench from relying on zero lag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cell_is_max <= '0;
            max_above_start <= 1'b0;
            charger_det <= 1'b0;
        end else begin
            cell_is_max <= want_max;
            max_above_start <= want_above;
            charger_det <= want_chg;
        end
    end
endmodule : cbc_pack_model

// >>> tb/cell_balance_controller_tb.sv
// Purpose: Self-checking bench of the cell balance controller.
// Assumes: Short phase, dwell and hour counts set below.
// Notes:   Timer windows allow 75 clocks, one and a half cycles, each way.
`timescale 1ns/1ns
`include "cbc_consts.svh"
module cell_balance_controller_tb import cbc_pkg::*; ;
    // ************************************************************
    // Signals, design and partner
    // ************************************************************
    localparam int MC = 10;
    localparam int CYC = MC + 40;
    localparam int HT = 4;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, above, chg, meas, frz;
    logic ov_t = 1'b0, uv_t = 1'b0, shut = 1'b0;
    logic want_above = 1'b0, want_chg = 1'b0;
    logic [7:0] want_max = 8'h00, cmax, bleed, ovd, uvd;
    logic [3:0] vth;
    int mismatches = 0, n_checks = 0, cyc = 0, t0 = 0, tt = 0;

    cbc_top #(.MEAS_CYC(MC), .BAL_CYC(40), .DWELL_TICKS(3),
        .HOUR_TICKS(HT)) uut (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cell_is_max(cmax), .max_above_start(above),
        .charger_det(chg), .ov_timing(ov_t), .uv_timing(uv_t),
        .shutdown_mode(shut), .bleed_drive(bleed), .meas_active(meas),
        .meas_freeze(frz), .start_vth_code(vth),
        .ov_delay_units(ovd), .uv_delay_units(uvd));
    cbc_pack_model u_pack (.pclk(pclk), .presetn(presetn),
        .want_max(want_max), .want_above(want_above),
        .want_chg(want_chg), .cell_is_max(cmax),
        .max_above_start(above), .charger_det(chg));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_bleed(input logic [7:0] exp);
        int n = 0;
        while (bleed !== exp && n < 600) begin
            @(posedge pclk);
            n++;
        end
        chk(bleed, exp);
    endtask : wait_bleed

    task automatic quiet(input int n);
        logic [7:0] seen = 8'h00;
        // Skip the model and gate lag before bleeding must be off.
        repeat (2) @(posedge pclk);
        repeat (n) begin
            @(posedge pclk);
            seen |= bleed;
        end
        chk(seen, 8'h00);
    endtask : quiet

    // ************************************************************
    // Clock, timeout and sequence
    // ************************************************************
    initial begin
        forever #25 pclk = ~pclk;
    end

    // A hang ends the run as a failure.
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        clk_en <= 1'b0;
        repeat (20) @(posedge pclk);
        chk(meas, 1'b1);
        clk_en <= 1'b1;
        apb(0, `CBC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_00f0);
        chk(vth, 4'hf);
        apb(0, `CBC_DLY_OFS, 32'h0);
        chk(rd, 32'h0000_0505);
        apb(0, 12'h00c, 32'h0);
        chk({er, rd[30:0]}, 32'h8000_0000);
        apb(1, `CBC_DLY_OFS, 32'h0000_0302);
        apb(0, `CBC_DLY_OFS, 32'h0);
        chk(rd, 32'h0000_0505);
        apb(1, `CBC_DLY_OFS, 32'h0000_1406);
        apb(0, `CBC_DLY_OFS, 32'h0);
        chk({rd[15:0], ovd, uvd}, 32'h1406_0614);
        want_max <= 8'h24;
        want_above <= 1'b1;
        want_chg <= 1'b1;
        apb(1, `CBC_CTRL_OFS, 32'h0000_0030);
        @(posedge pclk);
        chk(vth, 4'h3);
        quiet(400);
        apb(1, `CBC_CTRL_OFS, {24'h0, 6'h0c, CBC_MODE_CHG});
        wait_bleed(8'h04);
        chk(frz, 1'b1);
        want_chg <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(bleed, 8'h00);
        want_chg <= 1'b1;
        wait_bleed(8'h04);
        for (int k = 0; k < 2; k++) begin
            ov_t <= (k == 0);
            uv_t <= (k == 1);
            quiet(60);
            ov_t <= 1'b0;
            uv_t <= 1'b0;
            wait_bleed(8'h04);
        end
        want_above <= 1'b0;
        quiet(60);
        want_above <= 1'b1;
        wait_bleed(8'h04);
        shut <= 1'b1;
        quiet(60);
        shut <= 1'b0;
        wait_bleed(8'h04);
        want_max <= 8'h80;
        t0 = cyc;
        wait_bleed(8'h80);
        chk(32'(cyc - t0 > 90), 32'h1);
        want_chg <= 1'b0;
        apb(1, `CBC_CTRL_OFS, {24'h0, 6'h0c, CBC_MODE_BOTH});
        quiet(400);
        for (int t = 0; t < 4; t++) begin
            tt = (1 << t) * HT * CYC;
            want_above <= (t != 0);
            apb(1, `CBC_CTRL_OFS, {24'h0, 4'h3, 2'(t), CBC_MODE_TIMER});
            if (t == 0) begin
                repeat (300) @(posedge pclk);
                want_above <= 1'b1;
            end
            t0 = cyc;
            if (t == 3) begin
                wait_bleed(8'h80);
            end
            while (cyc < t0 + tt - 75) @(posedge pclk);
            apb(0, `CBC_STAT_OFS, 32'h0);
            chk(rd & 32'h0000_0400, 32'h0);
            repeat (150) @(posedge pclk);
            apb(0, `CBC_STAT_OFS, 32'h0);
            chk(rd & 32'h0000_0400, 32'h0000_0400);
            quiet(400);
        end
        give_verdict();
    end
endmodule : cell_balance_controller_tb

bind cbc_top cbc_monitor #(.N_CELLS(N_CELLS), .MEAS_CYC(MEAS_CYC)) u_mon (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pready(pready), .max_above_start(max_above_start),
    .ov_timing(ov_timing), .uv_timing(uv_timing),
    .shutdown_mode(shutdown_mode), .bleed_drive(bleed_drive),
    .meas_active(meas_active), .meas_freeze(meas_freeze),
    .ov_delay_units(ov_delay_units), .uv_delay_units(uv_delay_units));
